// File: verilog/pfl_pkg.sv
// Shared constants and carrier types for the program lock, fuse and signature block.
// Assumes a single 40 MHz core clock; all serial link timing is sampled by that clock.
package pfl_pkg;

	// Core clock and write timing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int WRITE_TIME_NS = 400;
	localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Serial instruction framing: opcode, address high, address low, data.
	localparam logic [4:0] BIT_LOAD_RDATA = 5'h17;
	localparam logic [4:0] BIT_LAST       = 5'h1F;

	// Opcodes carried in the first byte of an instruction.
	localparam logic [7:0] OP_CHIP_ERASE = 8'hAC;
	localparam logic [7:0] OP_WR_FLASH   = 8'h40;
	localparam logic [7:0] OP_RD_FLASH   = 8'h20;
	localparam logic [7:0] OP_WR_EEPROM  = 8'hC0;
	localparam logic [7:0] OP_RD_EEPROM  = 8'hA0;
	localparam logic [7:0] OP_WR_LOCK    = 8'hE0;
	localparam logic [7:0] OP_WR_FUSE    = 8'hE8;
	localparam logic [7:0] OP_RD_CONFIG  = 8'h58;
	localparam logic [7:0] OP_RD_SIG     = 8'h30;

	// Port pin positions.
	localparam int PORT_PIN_ZERO  = 0;
	localparam int PORT_PIN_ONE   = 1;
	localparam int PORT_PIN_TWO   = 2;
	localparam int PORT_PIN_THREE = 3;

	// Fuse write data bit positions.
	localparam int FUSE_DL_BIT   = 0;
	localparam int FUSE_FAST_BIT = 1;
	localparam int FUSE_OSC_BIT  = 2;

	// Reset values and fixed answers.
	localparam logic [7:0]      ERASED_BYTE     = 8'hFF;
	localparam logic [7:0]      BLOCKED_BYTE    = 8'hFF;
	localparam logic [2:0][7:0] SIG_PLACEHOLDER = {8'h02, 8'h01, 8'h00};

	typedef struct packed {
		logic internal_osc_enable_fuse;
		logic fast_startup_fuse;
		logic serial_download_enable_fuse;
	} pfl_fuse_t;

	typedef struct packed {
		logic lock_bit_two;
		logic lock_bit_one;
	} pfl_lock_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe_n;
	} pfl_pad_t;

	localparam pfl_fuse_t FUSE_DEFAULT = 3'h0;
	localparam pfl_lock_t LOCK_ERASED  = 2'h3;

endpackage

// File: verilog/pfl_core.sv
// Programming protection, fuse latches, signature space and port pin reuse.
// Assumes pads and programmer live outside the 40 MHz clock domain; por_pulse and the
// core port controls come from logic on the same clock.
// Function
// RULE1: Five-pin part: pin three is I/O if oscillator fuse programmed, else clock input.
// RULE2: In programming mode pin two is the serial clock input.
// RULE3: Selected counter clock pin edges tick the counter even when pin is output.
// RULE4: In programming mode pin one drives the serial data output.
// RULE5: External interrupt pin activity triggers even when the pin is an output.
// RULE6: In programming mode pin zero is the serial data input.
// RULE7: Two lock bits, one unprogrammed, zero programmed; only chip erase clears them.
// RULE8: Mode two blocks Flash and EEPROM writes; mode one protects nothing.
// RULE9: Mode three adds refusal of memory readback to mode two.
// RULE10: In high-voltage mode an active lock also blocks fuse writes.
// RULE11: Download fuse zero enables serial download; unreachable in low-voltage mode.
// RULE12: Three-pin part: fast start-up fuse zero selects shortest start, after power-on.
// RULE13: Five-pin part: oscillator fuse zero selects internal RC, after power-on.
// RULE14: Chip erase keeps fuses, clears arrays and lock bits.
// RULE15: Three signature bytes at addresses zero to two, readable when programming.
// RULE16: Lock mode three low-voltage signature reads return zero, one, two.
// RULE17: Flash and EEPROM start erased, every byte all ones.
// RULE18: Two programming modes: high-voltage enable level and low-voltage in-system.
// RULE19: Both modes write memory one byte per write operation.
// RULE20: Low-voltage EEPROM byte write erases the byte before writing it.
// RULE21: Serial data is sampled and updated on the serial clock rising edge.
// RULE22: Fuses and lock bits are latched at power-on reset and gate behaviour.
`timescale 1ns/100ps
module pfl_core #(
	parameter int              FLASH_DEPTH = 2048,
	parameter int              EE_DEPTH    = 128,
	parameter bit              FIVE_PIN    = 1'b1,
	parameter logic [2:0][7:0] SIGNATURE   = {8'h3C, 8'hA5, 8'h5A} // Arbitrary identity value.
) (
	input  wire logic               clock,           // Core clock, 40 MHz.
	input  wire logic               sys_rst,         // Synchronous reset, active high.
	input  wire logic               por_pulse,       // Power-on reset event, one cycle.
	input  wire logic               hv_enable_in,    // High-voltage enable level pin.
	input  wire logic               lv_prog_req_in,  // Low-voltage programming request pin.
	input  wire logic [3:0]         pad_in,          // Port pin levels, pins zero to three.
	input  wire logic [3:0]         core_pin_out,    // Core drive values for the port pins.
	input  wire logic [3:0]         core_pin_dir,    // Core directions, one means output.
	input  wire logic               counter_ext_sel, // Core selects external counter clock.
	output pfl_pkg::pfl_pad_t       pad_drv,         // Pin drive values and low-true enables.
	output logic                    prog_active,     // Serial programming mode active.
	output logic                    hv_mode,         // Active mode is the high-voltage one.
	output logic                    ready,           // No self-timed operation running.
	output logic                    counter_tick,    // One-cycle external counter clock tick.
	output logic                    ext_int_event,   // One-cycle external interrupt event.
	output pfl_pkg::pfl_fuse_t      fuse_cfg,        // Fuse values latched at power-on.
	output pfl_pkg::pfl_lock_t      lock_cfg         // Lock bits latched at power-on.
);

	localparam int FLASH_AW = $clog2(FLASH_DEPTH);
	localparam int EE_AW    = $clog2(EE_DEPTH);

	typedef struct packed {
		logic [3:0]                   pin_meta;
		logic [3:0]                   pin_sync;
		logic [3:0]                   pin_last;
		logic                         hv_meta;
		logic                         hv_sync;
		logic                         lv_meta;
		logic                         lv_sync;
		logic                         prog;
		logic                         hv_mode;
		logic [4:0]                   bit_cnt;
		logic [31:0]                  rx;
		logic [7:0]                   tx;
		logic [15:0]                  busy_cnt;
		pfl_pkg::pfl_fuse_t           fuse_nv;
		pfl_pkg::pfl_fuse_t           fuse_lat;
		pfl_pkg::pfl_lock_t           lock_nv;
		pfl_pkg::pfl_lock_t           lock_lat;
		logic [FLASH_DEPTH-1:0][7:0]  flash;
		logic [EE_DEPTH-1:0][7:0]     eeprom;
		pfl_pkg::pfl_pad_t            pad;
		logic                         ready;
		logic                         tick;
		logic                         int_ev;
	} pfl_state_t;

	pfl_state_t s_q;
	pfl_state_t s_d;

	logic                sck_rise;
	logic                int_change;
	logic [31:0]         rx_new;
	logic [7:0]          op_x;
	logic [7:0]          data_x;
	logic [FLASH_AW-1:0] fa_x;
	logic [EE_AW-1:0]    ea_x;
	logic [FLASH_AW-1:0] fa_l;
	logic [EE_AW-1:0]    ea_l;
	logic                wr_block;
	logic                vfy_block;
	logic                exec;
	logic                load;
	logic [7:0]          rdata;

	// Only the second synchroniser stage and its delayed copy feed edge detection.
	assign sck_rise   = s_q.pin_sync[pfl_pkg::PORT_PIN_TWO] & ~s_q.pin_last[pfl_pkg::PORT_PIN_TWO];
	assign int_change = s_q.pin_sync[pfl_pkg::PORT_PIN_ONE] ^ s_q.pin_last[pfl_pkg::PORT_PIN_ONE];
	assign rx_new     = {s_q.rx[30:0], s_q.pin_sync[pfl_pkg::PORT_PIN_ZERO]}; // [RULE6] [RULE21]
	assign op_x       = rx_new[31:24];
	assign data_x     = rx_new[7:0];
	assign fa_x       = FLASH_AW'(rx_new[23:8]);
	assign ea_x       = EE_AW'(rx_new[15:8]);
	assign fa_l       = FLASH_AW'(rx_new[15:0]);
	assign ea_l       = EE_AW'(rx_new[7:0]);
	assign load       = s_q.prog & sck_rise & (s_q.bit_cnt == pfl_pkg::BIT_LOAD_RDATA);
	assign exec       = s_q.prog & sck_rise & (s_q.bit_cnt == pfl_pkg::BIT_LAST)
	                    & (s_q.busy_cnt == 16'h0000);
	// Unlisted combination (two programmed, one not) is also treated as write protected.
	assign wr_block   = ~(s_q.lock_lat.lock_bit_one & s_q.lock_lat.lock_bit_two); // [RULE8]
	assign vfy_block  = ~s_q.lock_lat.lock_bit_one & ~s_q.lock_lat.lock_bit_two;  // [RULE9]

	// Answer byte, chosen once opcode and address are in; shifted out over the data byte.
	always_comb begin
		case (rx_new[23:16])
			pfl_pkg::OP_RD_FLASH:
				rdata = vfy_block ? pfl_pkg::BLOCKED_BYTE : s_q.flash[fa_l]; // [RULE9]
			pfl_pkg::OP_RD_EEPROM:
				rdata = vfy_block ? pfl_pkg::BLOCKED_BYTE : s_q.eeprom[ea_l]; // [RULE9]
			pfl_pkg::OP_RD_SIG: begin
				if (rx_new[1:0] == 2'h3)
					rdata = pfl_pkg::ERASED_BYTE;
				else if (vfy_block && !s_q.hv_mode)
					rdata = pfl_pkg::SIG_PLACEHOLDER[rx_new[1:0]]; // [RULE16]
				else
					rdata = SIGNATURE[rx_new[1:0]]; // [RULE15]
			end
			pfl_pkg::OP_RD_CONFIG:
				rdata = {3'h0, s_q.lock_nv, s_q.fuse_nv};
			default:
				rdata = pfl_pkg::ERASED_BYTE;
		endcase
	end

	always_comb begin
		s_d          = s_q;
		s_d.pin_meta = pad_in;
		s_d.pin_sync = s_q.pin_meta;
		s_d.pin_last = s_q.pin_sync;
		s_d.hv_meta  = hv_enable_in;
		s_d.hv_sync  = s_q.hv_meta;
		s_d.lv_meta  = lv_prog_req_in;
		s_d.lv_sync  = s_q.lv_meta;
		s_d.tick     = 1'b0;
		s_d.int_ev   = 1'b0;
		if (s_q.busy_cnt != 16'h0000) begin
			s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
		end
		// Stored fuse changes only reach the rest of the chip here.
		if (por_pulse) begin
			s_d.fuse_lat = s_q.fuse_nv; // [RULE22] [RULE12] [RULE13]
			s_d.lock_lat = s_q.lock_nv; // [RULE22]
		end
		// Low-voltage entry needs the latched download fuse programmed.
		s_d.prog = s_q.hv_sync
		           | (s_q.lv_sync & ~s_q.fuse_lat.serial_download_enable_fuse); // [RULE18] [RULE11]
		if (!s_q.prog) begin
			s_d.hv_mode = s_q.hv_sync; // [RULE18]
			s_d.bit_cnt = 5'h00;
			s_d.tx      = pfl_pkg::ERASED_BYTE;
			if (sck_rise && counter_ext_sel) begin
				s_d.tick = 1'b1; // [RULE3]
			end
			if (int_change) begin
				s_d.int_ev = 1'b1; // [RULE5]
			end
		end else if (sck_rise) begin
			s_d.rx      = rx_new; // [RULE2] [RULE21]
			s_d.bit_cnt = s_q.bit_cnt + 5'h01;
			if (s_q.bit_cnt == pfl_pkg::BIT_LOAD_RDATA) begin
				s_d.tx = rdata;
			end else begin
				s_d.tx = {s_q.tx[6:0], 1'b1}; // [RULE21]
			end
		end
		// A frame that completes while busy is not executed; a read frame still shifts out its answer.
		if (exec) begin
			case (op_x)
				pfl_pkg::OP_CHIP_ERASE: begin
					s_d.flash    = '1;                   // [RULE14]
					s_d.eeprom   = '1;                   // [RULE14]
					s_d.lock_nv  = pfl_pkg::LOCK_ERASED; // [RULE7] [RULE14]
					s_d.lock_lat = pfl_pkg::LOCK_ERASED; // [RULE7]
					s_d.busy_cnt = 16'(pfl_pkg::WRITE_CYCLES);
				end
				pfl_pkg::OP_WR_FLASH: begin
					if (!wr_block) begin
						s_d.flash[fa_x] = s_q.flash[fa_x] & data_x; // [RULE8] [RULE19]
						s_d.busy_cnt    = 16'(pfl_pkg::WRITE_CYCLES);
					end
				end
				pfl_pkg::OP_WR_EEPROM: begin
					if (!wr_block) begin
						// Low-voltage writes erase first, so the byte ends equal to the data.
						if (s_q.hv_mode)
							s_d.eeprom[ea_x] = s_q.eeprom[ea_x] & data_x; // [RULE19]
						else
							s_d.eeprom[ea_x] = data_x; // [RULE20]
						s_d.busy_cnt = 16'(pfl_pkg::WRITE_CYCLES);
					end
				end
				pfl_pkg::OP_WR_LOCK: begin
					s_d.lock_nv  = s_q.lock_nv & data_x[1:0]; // [RULE7]
					s_d.busy_cnt = 16'(pfl_pkg::WRITE_CYCLES);
				end
				pfl_pkg::OP_WR_FUSE: begin
					if (!(s_q.hv_mode && wr_block)) begin // [RULE10]
						s_d.fuse_nv.internal_osc_enable_fuse = data_x[pfl_pkg::FUSE_OSC_BIT];
						s_d.fuse_nv.fast_startup_fuse        = data_x[pfl_pkg::FUSE_FAST_BIT];
						if (s_q.hv_mode) begin
							s_d.fuse_nv.serial_download_enable_fuse =
								data_x[pfl_pkg::FUSE_DL_BIT]; // [RULE11]
						end
						s_d.busy_cnt = 16'(pfl_pkg::WRITE_CYCLES);
					end
				end
				default: begin
				end
			endcase
		end
		s_d.ready = (s_d.busy_cnt == 16'h0000);
		// Pin inputs stay readable whatever the direction, so alternate inputs work outside programming mode.
		s_d.pad.out  = core_pin_out;
		s_d.pad.oe_n = ~core_pin_dir;
		if (s_d.prog) begin
			s_d.pad.oe_n[pfl_pkg::PORT_PIN_ZERO] = 1'b1;     // [RULE6]
			s_d.pad.oe_n[pfl_pkg::PORT_PIN_TWO]  = 1'b1;     // [RULE2]
			s_d.pad.oe_n[pfl_pkg::PORT_PIN_ONE]  = 1'b0;     // [RULE4]
			s_d.pad.out[pfl_pkg::PORT_PIN_ONE]   = s_d.tx[7]; // [RULE4]
		end
		if (!FIVE_PIN || s_d.fuse_lat.internal_osc_enable_fuse) begin
			s_d.pad.oe_n[pfl_pkg::PORT_PIN_THREE] = 1'b1; // [RULE1]
			s_d.pad.out[pfl_pkg::PORT_PIN_THREE]  = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q          <= '0;
			s_q.flash    <= '1; // [RULE17]
			s_q.eeprom   <= '1; // [RULE17]
			s_q.tx       <= pfl_pkg::ERASED_BYTE;
			s_q.lock_nv  <= pfl_pkg::LOCK_ERASED;
			s_q.lock_lat <= pfl_pkg::LOCK_ERASED;
			s_q.fuse_nv  <= pfl_pkg::FUSE_DEFAULT;
			s_q.fuse_lat <= pfl_pkg::FUSE_DEFAULT;
			s_q.pad.oe_n <= 4'hF;
			s_q.ready    <= 1'b1;
			// Prime the pin synchroniser with live levels, so pin one's pull-up is no false edge.
			s_q.pin_meta <= pad_in;
			s_q.pin_sync <= s_q.pin_meta;
			s_q.pin_last <= s_q.pin_sync;
		end else begin
			s_q <= s_d;
		end
	end

	assign pad_drv       = s_q.pad;
	assign prog_active   = s_q.prog;
	assign hv_mode       = s_q.hv_mode;
	assign ready         = s_q.ready;
	assign counter_tick  = s_q.tick;
	assign ext_int_event = s_q.int_ev;
	assign fuse_cfg      = s_q.fuse_lat;
	assign lock_cfg      = s_q.lock_lat;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence SEQ_EXEC_WR_FLASH;
		exec && op_x == pfl_pkg::OP_WR_FLASH;
	endsequence

	sequence SEQ_EXEC_ERASE;
		exec && op_x == pfl_pkg::OP_CHIP_ERASE;
	endsequence

	sequence SEQ_EXEC_LV_EE;
		exec && op_x == pfl_pkg::OP_WR_EEPROM && !s_q.hv_mode && !wr_block;
	endsequence

	sequence SEQ_EXEC_HV_FUSE_LOCKED;
		exec && op_x == pfl_pkg::OP_WR_FUSE && s_q.hv_mode && wr_block;
	endsequence

	AST_PIN3_CLOCK_IN: assert property ( // [RULE1]
		(!FIVE_PIN || fuse_cfg.internal_osc_enable_fuse) |-> pad_drv.oe_n[3]
	) else $error("Pin three driven while it must be the clock input.");

	AST_COUNTER_TICK: assert property ( // [RULE3]
		(!s_q.prog && sck_rise && counter_ext_sel && core_pin_dir[2]) |=> counter_tick
	) else $error("Counter pin edge missed while pin set as output.");

	AST_MISO_DRIVE: assert property ( // [RULE4]
		prog_active |-> (!pad_drv.oe_n[1] && pad_drv.oe_n[0] && pad_drv.oe_n[2])
	) else $error("Programming pin directions wrong.");

	AST_INT_EVENT: assert property ( // [RULE5]
		(!s_q.prog && int_change) |=> ext_int_event
	) else $error("Interrupt pin activity did not raise an event.");

	AST_WRITE_LOCKED: assert property ( // [RULE8]
		(SEQ_EXEC_WR_FLASH and wr_block) |=> ($stable(s_q.flash) && ready)
	) else $error("Flash changed under write protection.");

	AST_VERIFY_LOCKED: assert property ( // [RULE9]
		(load && vfy_block && rx_new[23:16] == pfl_pkg::OP_RD_FLASH)
		|=> (s_q.tx == pfl_pkg::BLOCKED_BYTE) ##1 (pad_drv.out[1] == 1'b1)
	) else $error("Readback returned data in lock mode three.");

	AST_HV_FUSE_BLOCK: assert property ( // [RULE10]
		SEQ_EXEC_HV_FUSE_LOCKED |=> $stable(s_q.fuse_nv)
	) else $error("Fuse written while locked in high-voltage mode.");

	AST_ERASE_KEEPS_FUSES: assert property ( // [RULE14]
		SEQ_EXEC_ERASE |=> ($stable(s_q.fuse_nv) && s_q.lock_nv == pfl_pkg::LOCK_ERASED
		                    && s_q.eeprom[0] == pfl_pkg::ERASED_BYTE && !ready)
	) else $error("Chip erase result wrong.");

	AST_SIG_PLACEHOLDER: assert property ( // [RULE16]
		(load && vfy_block && !s_q.hv_mode && rx_new[23:16] == pfl_pkg::OP_RD_SIG
		 && rx_new[1:0] != 2'h3) |=> (s_q.tx == {6'h00, $past(rx_new[1:0])})
	) else $error("Locked signature read returned the true bytes.");

	AST_LV_EE_ERASE: assert property ( // [RULE20]
		SEQ_EXEC_LV_EE |=> (s_q.eeprom[$past(ea_x)] == $past(data_x)) ##[1:40] ready
	) else $error("Low-voltage EEPROM write did not erase then write.");

	AST_LV_NEEDS_FUSE: assert property ( // [RULE11]
		(s_q.lv_sync && !s_q.hv_sync && s_q.fuse_lat.serial_download_enable_fuse)
		|=> !prog_active
	) else $error("Low-voltage entry allowed with the download fuse unprogrammed.");

	AST_POR_LATCH: assert property ( // [RULE22]
		(por_pulse && !exec) |=> (fuse_cfg == $past(s_q.fuse_nv) && lock_cfg == $past(s_q.lock_nv))
	) else $error("Configuration latches not loaded at power-on.");

endmodule // pfl_core

// File: tb/pfl_prog_model.sv
// Behavioural serial programmer for the programming link: shifts 32-bit frames MSB first.
// Assumes the bench resolves the pin levels and hands the level of pin one back on miso.
`timescale 1ns/100ps
module pfl_prog_model (
	output logic      sck,  // Serial clock towards pin two.
	output logic      mosi, // Serial data towards pin zero.
	input  wire logic miso  // Level seen on pin one.
);
	initial begin
		sck = 1'b0;
		mosi = 1'b1;
	end

	// The clock stands low between frames. The data line then shows the inverse of its last
	// bit, so that a stale level can never pass for a freshly driven one.
	task automatic xfer(input logic [31:0] frame, output logic [7:0] rd);
		for (int i = 31; i >= 0; i--) begin
			mosi = frame[i]; // Data settles in the low phase and is taken on the rise.
			#100;
			if (i < 8) begin
				rd[i] = miso; // Answer bits are taken just before the following rise.
			end
			sck = 1'b1;
			#100;
			sck = 1'b0;
		end
		mosi = ~frame[0];
	endtask
endmodule // pfl_prog_model

// File: tb/pfl_core_tb.sv
// Self-checking bench for the lock, fuse and signature block with a serial programmer model.
// Assumes the package and the core module are compiled first; pin one has a pull-up.
`timescale 1ns/100ps
module pfl_core_tb;
	localparam logic [2:0][7:0] SIG = {8'h3C, 8'hA5, 8'h5A}; // Arbitrary identity value.
	logic               clock = 1'b0;
	logic               sys_rst = 1'b1;
	logic               por_pulse = 1'b0;
	logic               hv_enable_in = 1'b0;
	logic               lv_prog_req_in = 1'b0;
	logic [3:0]         core_pin_out = 4'h0;
	logic [3:0]         core_pin_dir = 4'h0;
	logic               counter_ext_sel = 1'b0;
	logic               sck;
	logic               mosi;
	logic [3:0]         pad_in;
	pfl_pkg::pfl_pad_t  pad_drv;
	pfl_pkg::pfl_fuse_t fuse_cfg;
	pfl_pkg::pfl_lock_t lock_cfg;
	logic               prog_active;
	logic               hv_mode;
	logic               ready;
	logic               counter_tick;
	logic               ext_int_event;
	logic [7:0]         rd;
	logic               seen;
	int                 bad_count = 0;
	int                 compares = 0;
	int                 tick_n = 0;
	int                 evt_n = 0;
	wire  [3:0]         ext = {1'b0, sck, 1'b1, mosi};

	// A pin follows the module wherever its low-true enable is asserted.
	assign pad_in = (pad_drv.oe_n & ext) | (~pad_drv.oe_n & pad_drv.out);

	always #12.5 clock = ~clock;

	always @(posedge clock) begin
		if (counter_tick === 1'b1) tick_n <= tick_n + 1;
		if (ext_int_event === 1'b1) evt_n <= evt_n + 1;
	end

	pfl_prog_model prog (.sck(sck), .mosi(mosi), .miso(pad_in[1]));

	pfl_core #(.FLASH_DEPTH(64), .SIGNATURE(SIG)) dut (
		.clock(clock), .sys_rst(sys_rst), .por_pulse(por_pulse), .hv_enable_in(hv_enable_in),
		.lv_prog_req_in(lv_prog_req_in), .pad_in(pad_in), .core_pin_out(core_pin_out),
		.core_pin_dir(core_pin_dir), .counter_ext_sel(counter_ext_sel), .pad_drv(pad_drv),
		.prog_active(prog_active), .hv_mode(hv_mode), .ready(ready),
		.counter_tick(counter_tick), .ext_int_event(ext_int_event), .fuse_cfg(fuse_cfg),
		.lock_cfg(lock_cfg));

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic por();
		por_pulse = 1'b1;
		step(1);
		por_pulse = 1'b0;
		step(1);
	endtask

	task automatic wait_prog(input logic lvl);
		int k;
		for (k = 0; k < 50 && prog_active !== lvl; k++) step(1);
		if (k == 50) begin
			bad_count++;
			close_out();
		end
	endtask

	// Waits out the longest self-timed write and reports whether ready ever dropped.
	task automatic wr(input logic [7:0] op, lo, dat, output logic busy);
		busy = 1'b0;
		prog.xfer({op, 8'h00, lo, dat}, rd);
		repeat (30) begin
			step(1);
			if (ready === 1'b0) busy = 1'b1;
		end
		cmp({7'h00, ready}, 8'h01);
	endtask

	task automatic rd_chk(input logic [7:0] op, lo, exp);
		prog.xfer({op, 8'h00, lo, 8'h00}, rd);
		cmp(rd, exp);
	endtask

	task automatic enter(input logic hv);
		hv_enable_in = hv;
		lv_prog_req_in = ~hv;
		wait_prog(1'b1);
		step(2);
		cmp({7'h00, hv_mode}, {7'h00, hv});
		cmp({5'h00, pad_drv.oe_n[2:0]}, 8'h05);
	endtask

	task automatic leave();
		hv_enable_in = 1'b0;
		lv_prog_req_in = 1'b0;
		wait_prog(1'b0);
		step(2);
	endtask

	task automatic t_reset();
		cmp({5'h00, fuse_cfg}, 8'h00);
		cmp({6'h00, lock_cfg}, 8'h03);
		cmp({4'h0, pad_drv.oe_n}, 8'h0F);
		cmp({7'h00, ready}, 8'h01);
	endtask

	// Pins one to three are outputs, so every edge below is made by the module itself.
	task automatic t_pins();
		int t0;
		int e0;
		counter_ext_sel = 1'b1;
		core_pin_out = 4'h2;
		core_pin_dir = 4'hE;
		step(8);
		cmp(8'(evt_n + tick_n), 8'h00);
		t0 = tick_n;
		e0 = evt_n;
		repeat (4) begin
			core_pin_out = core_pin_out ^ 4'h6;
			step(8);
		end
		cmp(8'(tick_n - t0), 8'h02);
		cmp(8'(evt_n - e0), 8'h04);
		core_pin_out = 4'hA;
		step(2);
		cmp({4'h0, pad_drv.oe_n}, 8'h01);
		cmp({4'h0, pad_drv.out[3]}, 8'h01);
		core_pin_dir = 4'h0;
		counter_ext_sel = 1'b0;
		step(8);
	endtask

	task automatic t_fresh();
		for (int k = 0; k < 4; k++) begin
			rd_chk(8'h30, 8'(k), (k < 3) ? SIG[k] : 8'hFF);
		end
		rd_chk(8'h20, 8'h05, 8'hFF);
		rd_chk(8'hA0, 8'h03, 8'hFF);
	endtask

	task automatic t_write();
		wr(8'h40, 8'h05, 8'hA5, seen);
		cmp({7'h00, seen}, 8'h01);
		rd_chk(8'h20, 8'h05, 8'hA5);
		wr(8'h40, 8'h05, 8'h0F, seen);
		rd_chk(8'h20, 8'h05, 8'h05);
		wr(8'hC0, 8'h03, 8'h3C, seen);
		wr(8'hC0, 8'h03, 8'hC3, seen);
		rd_chk(8'hA0, 8'h03, 8'hC3);
	endtask

	// The download fuse bit in the write is ignored in the low-voltage mode.
	task automatic t_fuse();
		wr(8'hE8, 8'h00, 8'h07, seen);
		rd_chk(8'h58, 8'h00, 8'h1E);
		cmp({5'h00, fuse_cfg}, 8'h00);
		por();
		cmp({5'h00, fuse_cfg}, 8'h06);
		leave();
		core_pin_dir = 4'h8;
		step(2);
		cmp({7'h00, pad_drv.oe_n[3]}, 8'h01);
		core_pin_dir = 4'h0;
		enter(1'b0);
	endtask

	task automatic t_lock();
		wr(8'hE0, 8'h00, 8'h02, seen);
		por();
		cmp({6'h00, lock_cfg}, 8'h02);
		wr(8'h40, 8'h06, 8'h00, seen);
		cmp({7'h00, seen}, 8'h00);
		rd_chk(8'h20, 8'h06, 8'hFF);
		rd_chk(8'h20, 8'h05, 8'h05);
		wr(8'hC0, 8'h03, 8'h00, seen);
		rd_chk(8'hA0, 8'h03, 8'hC3);
		wr(8'hE0, 8'h00, 8'h00, seen);
		por();
		rd_chk(8'h20, 8'h05, 8'hFF);
		for (int k = 0; k < 3; k++) begin
			rd_chk(8'h30, 8'(k), 8'(k));
		end
	endtask

	// Programmer side orders fuses before locks; here a late fuse write must bounce.
	task automatic t_erase();
		leave();
		enter(1'b1);
		wr(8'hE8, 8'h00, 8'h00, seen);
		rd_chk(8'h30, 8'h01, SIG[1]);
		wr(8'hAC, 8'h00, 8'h00, seen);
		cmp({6'h00, lock_cfg}, 8'h03);
		cmp({5'h00, fuse_cfg}, 8'h06);
		rd_chk(8'h58, 8'h00, 8'h1E);
		rd_chk(8'h20, 8'h05, 8'hFF);
		wr(8'hE8, 8'h00, 8'h01, seen);
		rd_chk(8'h58, 8'h00, 8'h19);
		por();
		leave();
		lv_prog_req_in = 1'b1;
		step(8);
		cmp({7'h00, prog_active}, 8'h00);
		lv_prog_req_in = 1'b0;
		step(4);
	endtask

	initial begin
		repeat (4) @(posedge clock);
		#2;
		sys_rst = 1'b0;
		step(1);
		t_reset();
		t_pins();
		enter(1'b0);
		t_fresh();
		t_write();
		t_fuse();
		t_lock();
		t_erase();
		close_out();
	end
endmodule // pfl_core_tb
